/* logic/dual_half_general_timer.sv */
// dual-half general timer with an AXI4-Lite register slave
//
// Functional notes
// (R1) reset: control cleared, both counters and load registers all ones
// (R2) reset: both prescale registers zero
// (R3) config 0 gives chained 32-bit down timer, 1 gives real-time counter
// (R4) config 4 splits into two independent 16-bit timers
// (R5) 32-bit mode: load A write fills A low, B high
// (R6) 32-bit mode: count A read returns B high, A low
// (R7) chained timer counts down; one-shot/periodic from half A mode only
// (R8) at zero reload next step; one-shot clears A enable, periodic continues
// (R9) chained time-out sets half A raw flag until cleared
// (R10) unmasked time-out sets masked flag and raises interrupt
// (R11) converter trigger pulses on half A time-out when its trigger enable set
// (R12) load write while running takes effect next cycle
// (R13) stall bit plus debug halt freezes counter; resumes afterwards
// (R14) real-time counter counts up, starts at one; later loads via match; the code loads the count through the 0x20 load write instead
// (R15) real-time input is 32.768 kHz pin divided to 1 Hz
// (R16) count equal to match rolls to zero and continues while enabled
// (R17) real-time match sets raw flag, masked flag, interrupt; clear bit clears
// (R18) real-time enable bit ignores stall bits during debug halt; the code does this in real-time mode only
// (R19) split halves: 16-bit down counter with 8-bit prescaler, own mode field
// (R20) half at zero reloads load and prescale; one-shot clears its enable
// (R21) half time-out sets raw, masked, interrupt, trigger as enabled
// (R22) prescale p gives p plus one clocks per count step
// (R23) counting only on clock edges; cleared enable holds the count
// (R24) writing one to a clear bit clears raw flag; zero leaves it
// (R25) trigger output is the OR of both halves' triggers
`timescale 1ns/10ps
module dual_half_general_timer
  import gen_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_halt,
  input wire logic capture_compare_pin,
  output logic timer_irq,
  output logic adc_trigger
);

  timer_state_t s_ff;
  timer_state_t nxt_s;

  // register map, byte offsets, one 32-bit word each
  // 0x00 configuration: chained, real-time or split
  // 0x04 and 0x08 mode field of half a and half b
  // 0x0c control: enables, stalls, real-time enable, triggers
  // 0x10 interrupt mask, same layout as the raw flags
  // 0x14 raw flags, 0x18 raw flags and mask, both read only
  // 0x1c clear: a one drops the matching raw flag, reads zero
  // 0x20 and 0x24 interval load of half a and half b
  // 0x28 real-time match value, 32 bits
  // 0x2c and 0x30 prescale of half a and half b
  // 0x34 and 0x38 live counts, read only
  // any other offset answers with a slave error

  // control bits: 0 enable a, 1 stall a, 4 real-time enable, 5 trigger a
  // half b uses 8, 9 and 13, one byte above its half a twins
  // flag bits: 0 time-out a, 3 real-time match, 8 time-out b

  // bus timing: address and data are held until both have arrived
  // the write lands on the next edge and raises the response with it
  // a read answers on the same edge that takes it
  // readies stay low while an answer waits for its master
  // so at most one write and one read are in flight

  // limitations and trade-offs
  // one packed state word keeps every register on one clock and reset
  // the capture pin passes two flops before the edge detector sees it
  // a pin level must last one clock or more to be caught
  // the debug halt comes from this clock domain and is used directly
  // a bus write beats a counter update in the same cycle
  // a time-out beats a clear in the same cycle, so no event is lost
  // in real-time mode only, the real-time enable overrides both stall bits during a halt
  // masked flags are formed on read rather than stored twice
  // real-time mode restarts at one on every entry, not only the first
  // any mode value other than one-shot runs periodic
  // the real-time tick needs 32768 pin edges, so it is slow to exercise

  // register read mux; bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input timer_state_t st, input logic [7:0] addr);
    logic [32:0] r;
    // unused bits read as zero; bit 32 drops for unmapped offsets
    r = {1'b1, 32'h0000_0000};
    case (addr & WORD_MASK)
      OFF_CONFIG: r[2:0] = st.cfg;
      OFF_MODE_A: r[1:0] = st.mode[0];
      OFF_MODE_B: r[1:0] = st.mode[1];
      OFF_CONTROL: r[15:0] = st.ctl;
      OFF_MASK: r[15:0] = st.imr;
      OFF_RAW: r[15:0] = st.ris;
      OFF_MASKED: r[15:0] = st.ris & st.imr;
      OFF_CLEAR: r[31:0] = 32'h0000_0000;
      OFF_LOAD_A: begin
        if (st.cfg == CFG_SPLIT16) begin
          r[15:0] = st.load[0];
        end else begin
          r[31:0] = {st.load[1], st.load[0]};
        end
      end
      OFF_LOAD_B: r[15:0] = st.load[1];
      OFF_MATCH_A: r[31:0] = st.match_a;
      OFF_PRESCALE_A: r[7:0] = st.prescale[0];
      OFF_PRESCALE_B: r[7:0] = st.prescale[1];
      OFF_COUNT_A: begin
        if (st.cfg == CFG_SPLIT16) begin
          r[15:0] = st.cnt[0];
        end else begin
          r[31:0] = {st.cnt[1], st.cnt[0]}; // [R6]
        end
      end
      OFF_COUNT_B: r[15:0] = st.cnt[1];
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction

  // expand byte strobes to a bit mask
  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // next-state logic: counting first, bus writes after so a write wins
  always_comb begin
    logic [31:0] cnt32;
    logic [15:0] set_flags;
    logic [15:0] clr_flags;
    logic [32:0] rd;
    logic [31:0] wval;
    logic [31:0] wmask;
    logic run;
    logic slow_edge;
    int eb;
    // every field holds unless a branch below moves it
    nxt_s = s_ff;
    cnt32 = {s_ff.cnt[1], s_ff.cnt[0]};
    set_flags = '0;
    clr_flags = '0;
    rd = '0;
    wval = '0;
    wmask = '0;
    run = 1'b0;
    slow_edge = 1'b0;
    eb = 0;
    // the trigger is a one-cycle pulse, low unless a time-out fires
    nxt_s.trig = 1'b0;

    // pin synchroniser, then an edge register for the slow clock
    nxt_s.pin_s1 = capture_compare_pin;
    nxt_s.pin_s2 = s_ff.pin_s1;
    nxt_s.pin_d = s_ff.pin_s2;
    // only the second flop feeds the edge detector
    slow_edge = s_ff.pin_s2 & ~s_ff.pin_d;

    // the 32-bit modes work on the joined counter; split mode runs further down
    case (s_ff.cfg)
      CFG_CHAIN32: begin
        // a stall only bites while the debugger holds the core
        run = s_ff.ctl[CTL_ENABLE] & ~(s_ff.ctl[CTL_STALL] & debug_halt); // [R13] [R23]
        if (run) begin
          // zero is a full step: reload, flag and trigger on one edge
          if (cnt32 == 32'h0000_0000) begin
            cnt32 = {s_ff.load[1], s_ff.load[0]}; // [R8]
            set_flags[ST_TIMEOUT] = 1'b1; // [R9]
            nxt_s.trig = s_ff.ctl[CTL_TRIGGER]; // [R11] [R25]
            // one-shot stops by dropping its own enable; any other mode runs on
            if (s_ff.mode[0] == MODE_ONE_SHOT) begin
              nxt_s.ctl[CTL_ENABLE] = 1'b0; // [R7] [R8]
            end
          end else begin
            cnt32 = cnt32 - 32'h0000_0001; // [R7]
          end
        end
      end
      CFG_CLOCK32: begin
        // the real-time enable overrides both stall bits
        run = s_ff.ctl[CTL_ENABLE] & (s_ff.ctl[CTL_CLOCK_EN] | ~(debug_halt &
              (s_ff.ctl[CTL_STALL] | s_ff.ctl[CTL_STALL + HALF_B_SHIFT]))); // [R18] [R13]
        // the divider moves only on synchronised rising pin edges
        if (run && slow_edge) begin
          if (s_ff.div == DIV_LAST) begin
            nxt_s.div = '0; // [R15]
            // a match rolls the count to zero instead of stopping it
            if (cnt32 == s_ff.match_a) begin
              cnt32 = 32'h0000_0000; // [R16]
              set_flags[ST_CLOCK_MATCH] = 1'b1; // [R17]
            end else begin
              cnt32 = cnt32 + 32'h0000_0001; // [R14]
            end
          end else begin
            nxt_s.div = s_ff.div + 15'h0001; // [R15]
          end
        end
      end
      CFG_SPLIT16: begin
        // the halves count on their own below
        cnt32 = cnt32;
      end
      default: begin
        // reserved configurations leave the counter alone
        cnt32 = cnt32;
      end
    endcase
    // hand the joined count back to the two halves
    nxt_s.cnt[0] = cnt32[15:0];
    nxt_s.cnt[1] = cnt32[31:16];

    // split mode: each half with its own prescaler
    if (s_ff.cfg == CFG_SPLIT16) begin
      for (int h = 0; h < 2; h++) begin
        // half b's control and status fields sit one byte above half a's
        eb = h * HALF_B_SHIFT;
        run = s_ff.ctl[CTL_ENABLE + eb] & ~(s_ff.ctl[CTL_STALL + eb] & debug_halt); // [R13] [R23]
        if (run) begin
          // the prescaler sets the step length; the count moves as it wraps
          if (s_ff.pre_cnt[h] == 8'h00) begin
            nxt_s.pre_cnt[h] = s_ff.prescale[h]; // [R22]
            if (s_ff.cnt[h] == 16'h0000) begin
              nxt_s.cnt[h] = s_ff.load[h]; // [R20]
              set_flags[ST_TIMEOUT + eb] = 1'b1; // [R21]
              // either half may pulse the shared trigger
              if (s_ff.ctl[CTL_TRIGGER + eb]) begin
                nxt_s.trig = 1'b1; // [R21] [R25]
              end
              if (s_ff.mode[h] == MODE_ONE_SHOT) begin
                nxt_s.ctl[CTL_ENABLE + eb] = 1'b0; // [R20]
              end
            end else begin
              nxt_s.cnt[h] = s_ff.cnt[h] - 16'h0001; // [R19]
            end
          end else begin
            nxt_s.pre_cnt[h] = s_ff.pre_cnt[h] - 8'h01; // [R22]
          end
        end
      end
    end

    // write channel capture; address and data may arrive in either order
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_have = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    // data may come before, with or after its address
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    // the response drops on the edge at which the master takes it
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end

    // perform the write once both halves of the request are held
    if (s_ff.aw_have && s_ff.w_have && !s_ff.bvalid) begin
      rd = reg_read(s_ff, s_ff.aw_addr);
      wmask = strobe_mask(s_ff.wstrb);
      wval = (rd[31:0] & ~wmask) | (s_ff.wdata & wmask);
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      // decode the held address; unknown offsets answer with a slave error
      case (s_ff.aw_addr & WORD_MASK)
        OFF_CONFIG: begin
          nxt_s.cfg = wval[2:0]; // [R3] [R4]
          // entering real-time mode restarts at one with the divider cleared
          if (wval[2:0] == CFG_CLOCK32) begin
            nxt_s.cnt[0] = CLOCK_START[15:0]; // [R14]
            nxt_s.cnt[1] = CLOCK_START[31:16];
            nxt_s.div = '0;
          end
        end
        OFF_MODE_A: nxt_s.mode[0] = wval[1:0];
        OFF_MODE_B: nxt_s.mode[1] = wval[1:0];
        OFF_CONTROL: nxt_s.ctl = wval[15:0] & CTL_MASK;
        OFF_MASK: nxt_s.imr = wval[15:0] & STATUS_MASK;
        // clearing uses the written ones, never the merged word
        OFF_CLEAR: clr_flags = (s_ff.wdata[15:0] & wmask[15:0]); // [R24]
        OFF_LOAD_A: begin
          // a load also restarts the count, so a new interval applies at once
          nxt_s.load[0] = wval[15:0];
          nxt_s.cnt[0] = wval[15:0]; // [R12]
          nxt_s.pre_cnt[0] = s_ff.prescale[0];
          // in the 32-bit modes the upper half of the word feeds half b
          if (s_ff.cfg != CFG_SPLIT16) begin
            nxt_s.load[1] = wval[31:16]; // [R5]
            nxt_s.cnt[1] = wval[31:16]; // [R12]
          end
        end
        // half b's own load also sets the upper half of the 32-bit count outside split mode
        OFF_LOAD_B: begin
          nxt_s.load[1] = wval[15:0];
          nxt_s.cnt[1] = wval[15:0]; // [R12]
          nxt_s.pre_cnt[1] = s_ff.prescale[1];
        end
        OFF_MATCH_A: nxt_s.match_a = wval; // [R14]
        OFF_PRESCALE_A: nxt_s.prescale[0] = wval[7:0];
        OFF_PRESCALE_B: nxt_s.prescale[1] = wval[7:0];
        OFF_RAW, OFF_MASKED, OFF_COUNT_A, OFF_COUNT_B: begin
          nxt_s.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: nxt_s.bresp = RESP_SLVERR;
      endcase
    end
    // readies come from the next state, so they fall with what they block
    nxt_s.awready = ~nxt_s.aw_have & ~nxt_s.bvalid;
    nxt_s.wready = ~nxt_s.w_have & ~nxt_s.bvalid;

    // read channel: one read in flight, answered the cycle after acceptance
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    // the read sees the state before this edge's updates
    if (s_axi_arvalid && s_ff.arready) begin
      rd = reg_read(s_ff, s_axi_araddr);
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd[31:0];
      nxt_s.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
    // no new read while an answer waits
    nxt_s.arready = ~nxt_s.rvalid;

    // set beats clear when both land in one cycle
    nxt_s.ris = ((s_ff.ris & ~clr_flags) | set_flags) & STATUS_MASK; // [R9] [R17] [R24]
    // the interrupt follows the masked flags of the new state
    nxt_s.irq = |(nxt_s.ris & nxt_s.imr); // [R10] [R17] [R21]
  end

  // single state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_ff <= STATE_RST; // [R1] [R2]
    end else begin
      s_ff <= nxt_s;
    end
  end

  // every output straight from the state register
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign timer_irq = s_ff.irq;
  assign adc_trigger = s_ff.trig;

endmodule

/* shared/gen_timer_pkg.sv */
// shared constants, register map and state layout for the dual-half general timer
package gen_timer_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_MODE_A = 8'h04;
  localparam logic [7:0] OFF_MODE_B = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_RAW = 8'h14;
  localparam logic [7:0] OFF_MASKED = 8'h18;
  localparam logic [7:0] OFF_CLEAR = 8'h1C;
  localparam logic [7:0] OFF_LOAD_A = 8'h20;
  localparam logic [7:0] OFF_LOAD_B = 8'h24;
  localparam logic [7:0] OFF_MATCH_A = 8'h28;
  localparam logic [7:0] OFF_PRESCALE_A = 8'h2C;
  localparam logic [7:0] OFF_PRESCALE_B = 8'h30;
  localparam logic [7:0] OFF_COUNT_A = 8'h34;
  localparam logic [7:0] OFF_COUNT_B = 8'h38;
  localparam logic [7:0] WORD_MASK = 8'hFC;
  // configuration values
  localparam logic [2:0] CFG_CHAIN32 = 3'h0;
  localparam logic [2:0] CFG_CLOCK32 = 3'h1;
  localparam logic [2:0] CFG_SPLIT16 = 3'h4;
  // mode field values
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  // control bit positions; half b fields sit HALF_B_SHIFT above half a
  localparam int CTL_ENABLE = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_CLOCK_EN = 4;
  localparam int CTL_TRIGGER = 5;
  localparam int HALF_B_SHIFT = 8;
  localparam logic [15:0] CTL_MASK = 16'h2333;
  // status bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_CLOCK_MATCH = 3;
  localparam logic [15:0] STATUS_MASK = 16'h0109;
  // reset and load values
  localparam logic [15:0] LOAD_RST = 16'hFFFF;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [31:0] CLOCK_START = 32'h0000_0001;
  // slow clock divider: 32.768 kHz edges to 1 Hz
  localparam int SLOW_CLK_HZ = 32768;
  localparam int TICK_HZ = 1;
  localparam logic [14:0] DIV_LAST = 15'((SLOW_CLK_HZ / TICK_HZ) - 1);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [2:0] cfg;
    logic [1:0][1:0] mode;
    logic [15:0] ctl;
    logic [15:0] imr;
    logic [15:0] ris;
    logic [1:0][15:0] load;
    logic [31:0] match_a;
    logic [1:0][7:0] prescale;
    logic [1:0][15:0] cnt;
    logic [1:0][7:0] pre_cnt;
    logic [14:0] div;
    logic pin_s1;
    logic pin_s2;
    logic pin_d;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic trig;
  } timer_state_t;

  localparam timer_state_t STATE_RST = '{
    cfg: CFG_CHAIN32, mode: '0, ctl: '0, imr: '0, ris: '0,
    load: {LOAD_RST, LOAD_RST}, match_a: '0, prescale: {PRESCALE_RST, PRESCALE_RST},
    cnt: {LOAD_RST, LOAD_RST}, pre_cnt: {PRESCALE_RST, PRESCALE_RST}, div: '0,
    pin_s1: 1'b0, pin_s2: 1'b0, pin_d: 1'b0, aw_have: 1'b0, aw_addr: '0,
    w_have: 1'b0, wdata: '0, wstrb: '0, awready: 1'b1, wready: 1'b1,
    bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0, rdata: '0,
    rresp: RESP_OKAY, irq: 1'b0, trig: 1'b0};
endpackage

/* testbench/dual_half_general_timer_properties.sv */
// port checker for the dual-half general timer, bound to the top module
`timescale 1ns/10ps
module timer_port_checker
  import gen_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_irq,
  input wire logic adc_trigger
);
  // one clock domain, so clocking and disable are shared
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  chk_reset_idle: assert property ($past(srst) |-> !timer_irq && !adc_trigger && s_axi_awready && s_axi_arready)
    else $error("outputs not idle after reset");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("illegal write response");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule

bind dual_half_general_timer timer_port_checker u_chk (.core_clk, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .timer_irq, .adc_trigger);

/* testbench/tb_dual_half_general_timer.sv */
// self-checking bench for the dual-half general timer
`timescale 1ns/10ps
module tb_dual_half_general_timer;
  import gen_timer_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, debug_halt = 1'b0, capture_compare_pin = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq, adc_trigger;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  int failures = 0, checked = 0, trig_seen = 0, seed = 17452, n;

  dual_half_general_timer DUT (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .debug_halt,
    .capture_compare_pin, .timer_irq, .adc_trigger);

  // 20 MHz clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    exp_q.push_back({RESP_OKAY, 32'h0000_0000});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (s_axi_awready) aw_done = 1'b1;
      if (s_axi_wready) w_done = 1'b1;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid <= !w_done;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    exp_q.push_back({r, e});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // scoreboard: every bus answer meets the oldest note; trigger pulses counted
  always @(posedge core_clk) begin
    if (adc_trigger === 1'b1) trig_seen++;
    if ((s_axi_bvalid && s_axi_bready) === 1'b1) check({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
    if ((s_axi_rvalid && s_axi_rready) === 1'b1) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    // reset values, the 32-bit view and an unmapped offset
    rd(OFF_LOAD_A, 32'hFFFF_FFFF);
    rd(OFF_COUNT_A, 32'hFFFF_FFFF);
    rd(OFF_PRESCALE_A, 32'h0000_0000);
    rd(OFF_PRESCALE_B, 32'h0000_0000);
    rd(OFF_CONTROL, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000, RESP_SLVERR);
    $display("test reset done");
    // chained one-shot; half b mode set to periodic must not matter
    rv = 32'h0000_0010 + ($random(seed) & 32'h0000_001F);
    wr(OFF_MODE_A, MODE_ONE_SHOT);
    wr(OFF_MODE_B, MODE_PERIODIC);
    wr(OFF_LOAD_A, 32'h0003_0010);
    rd(OFF_LOAD_B, 32'h0000_0003);
    rd(OFF_COUNT_A, 32'h0003_0010);
    wr(OFF_LOAD_A, rv);
    wr(OFF_MASK, 32'h0000_0001);
    wr(OFF_CONTROL, 32'h0000_0021);
    repeat (rv + 8) @(posedge core_clk);
    rd(OFF_CONTROL, 32'h0000_0020);
    rd(OFF_COUNT_A, rv);
    rd(OFF_MASKED, 32'h0000_0001);
    check(timer_irq, 1);
    check(trig_seen, 1);
    wr(OFF_CLEAR, 32'h0000_0000);
    rd(OFF_RAW, 32'h0000_0001);
    wr(OFF_CLEAR, 32'h0000_0001);
    rd(OFF_RAW, 32'h0000_0000);
    check(timer_irq, 0);
    $display("test one-shot done");
    // periodic run frozen by a halt; a load written meanwhile lands at once
    debug_halt <= 1'b1;
    wr(OFF_MODE_A, MODE_PERIODIC);
    wr(OFF_CONTROL, 32'h0000_0003);
    rd(OFF_COUNT_A, rv);
    wr(OFF_LOAD_A, 32'h0000_0009);
    rd(OFF_COUNT_A, 32'h0000_0009);
    debug_halt <= 1'b0;
    repeat (40) @(posedge core_clk);
    rd(OFF_CONTROL, 32'h0000_0003);
    rd(OFF_RAW, 32'h0000_0001);
    check(trig_seen, 1);
    wr(OFF_CONTROL, 32'h0000_0000);
    wr(OFF_CLEAR, 32'h0000_0001);
    $display("test periodic done");
    // split halves: half b one-shot, prescale written before the load
    wr(OFF_CONFIG, CFG_SPLIT16);
    wr(OFF_MODE_B, MODE_ONE_SHOT);
    wr(OFF_PRESCALE_B, 32'h0000_0003);
    wr(OFF_LOAD_B, 32'h0000_0005);
    wr(OFF_MASK, 32'h0000_0100);
    wr(OFF_CONTROL, 32'h0000_2100);
    n = 0;
    while (adc_trigger !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    // six steps of four clocks, counted from the control write's response
    check(n, 24);
    rd(OFF_CONTROL, 32'h0000_2000);
    rd(OFF_COUNT_B, 32'h0000_0005);
    rd(OFF_RAW, 32'h0000_0100);
    check(timer_irq, 1);
    check(trig_seen, 2);
    $display("test split done");
    // real-time start value; a 1 Hz tick is far beyond the run length
    wr(OFF_CLEAR, 32'h0000_0109);
    wr(OFF_CONFIG, CFG_CLOCK32);
    rd(OFF_COUNT_A, 32'h0000_0001);
    rd(OFF_CONFIG, 32'h0000_0001);
    // a few pin edges must not move the count before the divider wraps
    wr(OFF_MATCH_A, 32'h0000_0005);
    wr(OFF_CONTROL, 32'h0000_0001);
    repeat (16) begin
      repeat (4) @(posedge core_clk);
      capture_compare_pin <= ~capture_compare_pin;
    end
    rd(OFF_COUNT_A, 32'h0000_0001);
    rd(OFF_MATCH_A, 32'h0000_0005);
    $display("test real-time done");
    summarize();
  end
endmodule
